/* hdl/odf_decode.sv */
// opcode classification and condition flag update
// assumes the datapath computes the result and its carries; this block
// decides which flags move and how, one opcode per update strobe
// the opcode map has holes; those cells decode as illegal and fetch nothing
// flags are five bits: carry, zero, negative, interrupt mask, half carry
// Functional notes
// - half carry taken from carry out of bit 3 where marked
// - affected flags follow their condition or are forced clear or set, unaffected flags hold
// - return from interrupt reloads all five flags from popped byte
// - short offset indexed fetches one byte, long offset fetches two
// - bit write mode kept apart from bit test branch mode
// - implied, literal, direct, full address are separate fetch classes by column
// - 59 basic operations over modes give 207 valid opcodes
// - test negative zero updates flags but suppresses write back
// - implied instructions use only the opcode byte
// - bit instructions reach only the first 256 bytes
module odf_decode (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // opcode in
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand_addr,
  // execution strobe and result
  input wire logic update,
  input wire odf_pkg::odf_res_t result,
  input wire logic [7:0] stacked_flags,
  // decode out
  output odf_pkg::odf_dec_t dec,
  output logic [15:0] bit_addr,
  // flags out
  output logic [4:0] flags
);
  import odf_pkg::*;

  // ==========================================================
  // column and row split
  wire logic [3:0] col = opcode[7:4];
  wire logic [3:0] row = opcode[3:0];

  // ==========================================================
  // column groups shared by the write-back and flag decoders;
  // the bit write column is read-modify-write in memory but moves no flag
  wire logic grp_bit_write = col == 4'h1;
  wire logic grp_rmw = col >= 4'h3 && col <= 4'h7;
  wire logic grp_regmem = col >= 4'hA;

  // legality of each map cell; holes in the map are illegal
  // the column sets the operand class, the row the operation
  function automatic logic cell_legal(input logic [3:0] c, input logic [3:0] r);
    logic rmw_ok;
    rmw_ok = !(r == 4'h1 || r == 4'h2 || r == 4'h5 || r == 4'hB || r == 4'hE);
    unique case (c)
      4'h0, 4'h1, 4'h2: cell_legal = 1'b1;
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7: cell_legal = rmw_ok;
      4'h8: cell_legal = (r == 4'h0 || r == 4'h1 || r == 4'h3);
      4'h9: cell_legal = (r == 4'h7 || (r >= 4'h8 && r <= 4'hD) || r == 4'hF);
      4'hA: cell_legal = !(r == 4'h7 || r == 4'hC || r == 4'hF);
      default: cell_legal = (r != 4'h7 && r != 4'hF) || c != 4'hA;
    endcase
  endfunction : cell_legal

  // ==========================================================
  // mode selection by column; 0xAD is relative (subroutine branch)
  wire logic legal = cell_legal(col, row);
  odf_mode_t mode;
  always_comb begin
    unique case (col)
      4'h0: mode = bit_test_branch_mode;
      4'h1: mode = bit_write_mode;
      4'h2: mode = pc_relative_mode;
      4'h3, 4'hB: mode = direct_mode;
      4'h4, 4'h5, 4'h8, 4'h9: mode = implied_mode;
      4'h6, 4'hE: mode = indexed_short_offset;
      4'h7, 4'hF: mode = indexed_no_offset;
      4'hA: mode = (row == 4'hD) ? pc_relative_mode : literal_operand_mode;
      4'hC: mode = full_address_mode;
      4'hD: mode = indexed_long_offset;
    endcase
    // holes in the map never reach a fetch class
    if (!legal) begin
      mode = illegal_mode;
    end
  end

  // ==========================================================
  // bytes after the opcode for each class; the fetch path steps the
  // program counter by this, so illegal cells fetch nothing
  logic [1:0] nbytes;
  always_comb begin
    unique case (mode)
      implied_mode, indexed_no_offset, illegal_mode: nbytes = 2'd0;
      indexed_short_offset: nbytes = 2'd1;
      indexed_long_offset, full_address_mode: nbytes = 2'd2;
      bit_test_branch_mode: nbytes = 2'd2;
      default: nbytes = 2'd1;
    endcase
  end

  // read-modify-write group writes back except for the test opcode;
  // the test row is matched in the rmw columns only, as the same row
  // in the bit write column is a bit clear that must write back
  wire logic is_rmw = grp_rmw || grp_bit_write;
  wire logic is_tst = grp_rmw && row == 4'hD;
  wire logic is_store = (row == 4'h7 || row == 4'hF) && col >= 4'hB;
  wire logic is_rti = opcode == 8'h80;

  // next decode word built beside the register so the flop stays short
  wire odf_dec_t next_dec = '{
    mode: mode,
    operand_bytes: nbytes,
    legal: legal,
    write_back: legal && (is_store || (is_rmw && !is_tst)),
    use_x: col == 4'h5,
    bit_sel: opcode[3:1]
  };

  // decode outputs registered so the datapath sees stable data
  always_ff @(posedge clk) begin
    if (srst) begin
      dec <= '{mode: illegal_mode, operand_bytes: 2'h0, legal: 1'b0, write_back: 1'b0,
        use_x: 1'b0, bit_sel: 3'h0};
      bit_addr <= 16'h0000;
    end else begin
      dec <= next_dec;
      bit_addr <= {8'h00, operand_addr};  // page zero only
    end
  end

  // ==========================================================
  // flag actions: H, I, N, Z, C
  odf_act_t act_h;
  odf_act_t act_i;
  odf_act_t act_n;
  odf_act_t act_z;
  odf_act_t act_c;
  // jump and subroutine cells of the register/memory columns move no
  // flag, nor does the relative subroutine branch in the literal column
  wire logic is_jump = grp_regmem && (row == 4'hC || row == 4'hD);
  wire logic is_alu = grp_regmem && legal && !is_jump;
  always_comb begin
    act_h = act_keep;
    act_i = act_keep;
    act_n = act_keep;
    act_z = act_keep;
    act_c = act_keep;
    // rmw rows test N and Z, except row 4 clearing N and row F clearing N and setting Z; shifts, rotates and negate also test C
    if (grp_rmw) begin
      act_n = act_test;
      act_z = act_test;
      unique case (row)
        4'h0, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9: act_c = act_test;
        4'h3: act_c = act_set;
        4'hF: begin
          act_n = act_clr;
          act_z = act_set;
        end
        default: act_c = act_keep;
      endcase
      if (row == 4'h4) begin
        act_n = act_clr;
      end
    end else if (is_alu) begin
      act_n = act_test;
      act_z = act_test;
      if (row <= 4'h3) begin
        act_c = act_test;
      end
      if (row == 4'h9 || row == 4'hB) begin
        act_h = act_test;
        act_c = act_test;
      end
    end else if (col == 4'h9) begin
      unique case (row)
        4'h8: act_c = act_clr;
        4'h9: act_c = act_set;
        4'hA: act_i = act_clr;
        4'hB: act_i = act_set;
        default: act_c = act_keep;
      endcase
    end else if (opcode == 8'h83) begin
      act_i = act_set;
    end
  end

  // one flag's next value from its action
  // keep, test, clear or set, as the flag table marks it
  function automatic logic flag_next(input odf_act_t a, input logic old, input logic cond);
    unique case (a)
      act_keep: flag_next = old;
      act_test: flag_next = cond;
      act_clr: flag_next = 1'b0;
      act_set: flag_next = 1'b1;
    endcase
  endfunction : flag_next

  // ==========================================================
  // flag conditions; the datapath owns the adder, so the half carry
  // arrives ready made as the carry out of the low nibble
  wire logic cond_h = result.half;
  wire logic cond_n = result.value[7];
  wire logic cond_z = result.value == 8'h00;
  wire logic cond_c = result.carry;

  // ==========================================================
  // flag register; the return from interrupt pop overrides every action
  logic [4:0] next_flags;
  always_comb begin
    next_flags[FLAG_H] = flag_next(act_h, flags[FLAG_H], cond_h);
    next_flags[FLAG_I] = flag_next(act_i, flags[FLAG_I], 1'b0);  // no result sets the mask
    next_flags[FLAG_N] = flag_next(act_n, flags[FLAG_N], cond_n);
    next_flags[FLAG_Z] = flag_next(act_z, flags[FLAG_Z], cond_z);
    next_flags[FLAG_C] = flag_next(act_c, flags[FLAG_C], cond_c);
    if (is_rti) begin
      next_flags = stacked_flags[4:0];
    end
  end

  // flags move only on the update strobe; between strobes the datapath
  // result may wander without disturbing them
  always_ff @(posedge clk) begin
    if (srst) begin
      flags <= FLAG_RESET;
    end else if (update) begin
      flags <= next_flags;
    end
  end

endmodule : odf_decode

/* hdl/odf_pkg.sv */
// package for the opcode decode and flag update block
// assumes an 8-bit core feeding one opcode byte per decode request
package odf_pkg;

  // ==========================================================
  // addressing mode classes
  typedef enum logic [3:0] {
    implied_mode,
    literal_operand_mode,
    direct_mode,
    full_address_mode,
    pc_relative_mode,
    indexed_no_offset,
    indexed_short_offset,
    indexed_long_offset,
    bit_write_mode,
    bit_test_branch_mode,
    illegal_mode
  } odf_mode_t;

  // ==========================================================
  // flag register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_I = 3;
  localparam int FLAG_H = 4;
  localparam int FLAG_W = 5;
  localparam logic [4:0] FLAG_RESET = 5'h08;  // interrupt mask set out of reset
  localparam int HALF_BIT = 3;                // half carry comes out of this bit
  localparam int BASIC_OPS = 59;
  localparam int VALID_OPCODES = 207;
  localparam logic [15:0] PAGE0_LIMIT = 16'h0100;

  // per-flag action
  typedef enum logic [1:0] {
    act_keep,
    act_test,
    act_clr,
    act_set
  } odf_act_t;

  // decode result carried to the datapath
  typedef struct packed {
    odf_mode_t mode;
    logic [1:0] operand_bytes;  // bytes fetched after the opcode
    logic legal;
    logic write_back;
    logic use_x;                // implied form working on the index register
    logic [2:0] bit_sel;
  } odf_dec_t;

  // arithmetic result presented by the datapath
  typedef struct packed {
    logic [7:0] value;
    logic carry;
    logic half;
  } odf_res_t;

endpackage : odf_pkg

/* dv/odf_alu_model.sv */
// datapath stand-in: adds two operands, reports carry and half carry
// assumes odf_pkg compiled first; purely combinational
module odf_alu_model
  import odf_pkg::*;
(
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  // result
  output wire odf_pkg::odf_res_t res
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // adder
  logic [8:0] sum;
  logic [4:0] low;
  assign sum = {1'b0, a} + {1'b0, b};
  // low nibble sum gives carry out of bit 3
  assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
  assign res = {sum[7:0], sum[8], low[4]};
endmodule : odf_alu_model

/* dv/odf_decode_sva.sv */
// port-level checker for the decode block
// assumes bind onto odf_decode, one clock, srst active high
module odf_decode_sva
  import odf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // inputs
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand_addr,
  input wire logic update,
  input wire odf_pkg::odf_res_t result,
  input wire logic [7:0] stacked_flags,
  // outputs
  input wire odf_pkg::odf_dec_t dec,
  input wire logic [15:0] bit_addr,
  input wire logic [4:0] flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_half_carry:
    assert property (update && opcode == 8'hAB |=> flags[FLAG_H] == $past(result.half)) else $error("half carry");
  a_flag_hold:
    assert property (update && opcode == 8'hA6 |=> flags[4:3] == $past(flags[4:3]) && flags[0] == $past(flags[0]))
      else $error("unaffected flag moved");
  a_pop_flags:
    assert property (update && opcode == 8'h80 |=> flags == $past(stacked_flags[4:0])) else $error("flag reload");
  a_short_offset:
    assert property (opcode[7:4] == 4'hE |=> dec.mode == indexed_short_offset && dec.operand_bytes == 2'h1)
      else $error("short offset");
  a_long_offset:
    assert property (opcode[7:4] == 4'hD |=> dec.mode == indexed_long_offset && dec.operand_bytes == 2'h2)
      else $error("long offset");
  a_bit_split:
    assert property (opcode[7:5] == 3'h0 |=> dec.mode == ($past(opcode[4]) ? bit_write_mode : bit_test_branch_mode)
      && dec.bit_sel == $past(opcode[3:1])) else $error("bit mode");
  a_full_address:
    assert property (opcode[7:4] == 4'hC |=> dec.mode == full_address_mode && dec.operand_bytes == 2'h2)
      else $error("full address");
  a_test_no_write:
    assert property (opcode == 8'h4D |=> dec.legal && !dec.write_back) else $error("test wrote back");
  a_implied_bytes:
    assert property (opcode == 8'h4C || opcode == 8'h5D || opcode == 8'h9D |=> dec.mode == implied_mode
      && dec.operand_bytes == 2'h0 && dec.legal) else $error("implied bytes");
  a_page_zero:
    assert property (opcode[7:5] == 3'h0 |=> bit_addr < PAGE0_LIMIT && bit_addr[7:0] == $past(operand_addr))
      else $error("bit address out of page");
  a_bit_write_back:
    assert property (opcode[7:4] == 4'h1 |=> dec.legal && dec.write_back) else $error("bit write lost");
  c_pop: cover property (update && opcode == 8'h80);
  c_bit: cover property (dec.mode == bit_write_mode);
  c_add: cover property (update && opcode == 8'hAB);
endmodule : odf_decode_sva

/* dv/tb.sv */
// self-checking bench for the decode block
// assumes package, design, datapath model and checker compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import odf_pkg::*;
  `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
  // =====
  // signals
  logic clk = 1'b0, srst = 1'b1, update = 1'b0;
  logic [7:0] opcode = 8'h00, operand_addr = 8'h00, stacked_flags = 8'h00, pa = 8'h00, pb = 8'h00;
  odf_res_t result;
  odf_dec_t dec;
  logic [15:0] bit_addr;
  logic [4:0] flags;
  int num_errors = 0, n_compared = 0, n_legal = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  odf_alu_model odf_alu_model_i (.a(pa), .b(pb), .res(result));
  odf_decode odf_decode_i (.clk(clk), .srst(srst), .opcode(opcode), .operand_addr(operand_addr), .update(update),
    .result(result), .stacked_flags(stacked_flags), .dec(dec), .bit_addr(bit_addr), .flags(flags));
  // =====
  // one opcode per call, update held a single cycle
  task automatic run(input logic [7:0] o, input logic [7:0] a, input logic [7:0] b, input logic u);
    @(posedge clk);
    opcode <= o;
    pa <= a;
    pb <= b;
    update <= u;
    @(posedge clk);
    update <= 1'b0;
    #1;
  endtask : run
  task automatic tally_and_finish();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // =====
  // tests
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK("reset flags", 5'h08, flags)
    for (int i = 0; i < 256; i++) begin
      run(8'(i), 8'h00, 8'h00, 1'b0);
      if (dec.legal === 1'b1) n_legal++;
    end
    `CHK("legal count", VALID_OPCODES, n_legal)
    @(posedge clk);
    operand_addr <= 8'hA5;
    stacked_flags <= 8'h15;
    run(8'h1A, 8'h00, 8'h00, 1'b0);
    `CHK("bit mode", bit_write_mode, dec.mode)
    `CHK("bit select", 3'h5, dec.bit_sel)
    `CHK("bit address", 16'h00A5, bit_addr)
    run(8'hAB, 8'h0F, 8'h01, 1'b1);
    `CHK("add half", 5'h18, flags)
    run(8'hAB, 8'h80, 8'h80, 1'b1);
    `CHK("add carry zero", 5'h0B, flags)
    run(8'h80, 8'h00, 8'h00, 1'b1);
    `CHK("pop flags", 5'h15, flags)
    run(8'hA6, 8'h00, 8'h00, 1'b1);
    `CHK("load keeps h i c", 5'h13, flags)
    `CHK("literal mode", literal_operand_mode, dec.mode)
    run(8'h98, 8'h00, 8'h00, 1'b1);
    `CHK("clear carry", 5'h12, flags)
    run(8'h43, 8'hFF, 8'h00, 1'b1);
    `CHK("complement sets c", 5'h15, flags)
    run(8'h9B, 8'h00, 8'h00, 1'b1);
    `CHK("set mask", 5'h1D, flags)
    run(8'h4F, 8'h00, 8'h00, 1'b1);
    `CHK("clear n0 z1", 5'h1B, flags)
    run(8'h44, 8'h01, 8'h00, 1'b1);
    `CHK("shift right n0", 5'h18, flags)
    run(8'h9A, 8'h00, 8'h00, 1'b1);
    `CHK("clear mask", 5'h10, flags)
    run(8'h83, 8'h00, 8'h00, 1'b1);
    `CHK("soft int mask", 5'h18, flags)
    run(8'h5D, 8'h80, 8'h00, 1'b1);
    `CHK("test flags", 5'h1C, flags)
    `CHK("test no write", 1'b0, dec.write_back)
    `CHK("index form", 1'b1, dec.use_x)
    `CHK("implied bytes", 2'h0, dec.operand_bytes)
    run(8'h1D, 8'h00, 8'h00, 1'b1);
    `CHK("bit clear writes", 1'b1, dec.write_back)
    `CHK("bit clear flags", 5'h1C, flags)
    run(8'hD6, 8'h00, 8'h00, 1'b0);
    `CHK("long offset bytes", 2'h2, dec.operand_bytes)
    run(8'h03, 8'h00, 8'h00, 1'b0);
    `CHK("bit branch mode", bit_test_branch_mode, dec.mode)
    `CHK("bit branch bytes", 2'h2, dec.operand_bytes)
    // second reset in mid-run
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK("mid reset flags", FLAG_RESET, flags)
    `CHK("mid reset legal", 1'b0, dec.legal)
    tally_and_finish();
  end
  // watchdog: tests need about 555 cycles, allow ample margin
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule : tb
bind odf_decode odf_decode_sva odf_decode_sva_i (.clk(clk), .srst(srst), .opcode(opcode),
  .operand_addr(operand_addr), .update(update), .result(result), .stacked_flags(stacked_flags), .dec(dec),
  .bit_addr(bit_addr), .flags(flags));
